//--- rtl/ilr_pkg.sv
// constants and types for the port ingress rate limiter
// assumes a 250 MHz core clock and apb register access
package ilr_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_CFG      = 8'h03;
    localparam logic [7:0]  IDX_PRIO0    = 8'h10;
    localparam logic [7:0]  IDX_PRIO7    = 8'h17;
    localparam logic [7:0]  IDX_STATUS   = 8'h20;
    localparam int          NUM_PRIO     = 8;
    localparam int          ADDR_W       = 12;

    // configuration field positions
    localparam int          CFG_PORT_BIT = 6;
    localparam int          CFG_PPS_BIT  = 5;
    localparam int          CFG_FC_BIT   = 4;
    localparam int          CFG_MODE_HI  = 3;
    localparam int          CFG_MODE_LO  = 2;
    localparam int          CFG_IFG_BIT  = 1;
    localparam int          CFG_PRE_BIT  = 0;
    localparam logic [7:0]  CFG_MASK     = 8'h7F;
    localparam logic [7:0]  CFG_RESET    = 8'h00;
    localparam logic [6:0]  CODE_RESET   = 7'h00;

    // per-frame overhead and packet cost
    localparam logic [15:0] IFG_BYTES    = 16'h000C;
    localparam logic [15:0] PRE_BYTES    = 16'h0008;
    localparam logic [31:0] PKT_COST     = 32'h0000_03E8;

    // credit refill period: rates are kb/s or packets/s, credit is bits
    // or millipackets per refill of one millisecond
    localparam int          CLK_PERIOD_NS  = 4;
    localparam int          REFILL_PERIOD_NS = 1000000;
    localparam int          REFILL_CYCLES  = REFILL_PERIOD_NS / CLK_PERIOD_NS;

    localparam int          RATE_W       = 21;
    localparam int          CRED_W       = 32;

    typedef enum logic [1:0]
    {
        SPD_10   = 2'b00,
        SPD_100  = 2'b01,
        SPD_1000 = 2'b10,
        SPD_RSVD = 2'b11
    } ilr_speed_t;

    typedef enum logic [1:0]
    {
        LIM_ALL       = 2'b00,
        LIM_BMF       = 2'b01,
        LIM_BM        = 2'b10,
        LIM_BCAST     = 2'b11
    } ilr_limit_t;

endpackage : ilr_pkg

//--- rtl/ilr_rate_decode.sv
// rate code decoder: 7-bit code to a rate in kb/s or packets/s
// combinational; speed and mode come from the limiter
`timescale 1ns/100ps
module ilr_rate_decode
    import ilr_pkg::*;
(
    // selection
    input  wire logic [6:0]        code,
    input  wire logic [1:0]        speed,
    input  wire logic              ppsMode,
    // result
    output logic      [RATE_W-1:0] rate
);

    logic [RATE_W-1:0] c;
    logic [RATE_W-1:0] lowIdx;

    always_comb
    begin
        c      = {{(RATE_W-7){1'b0}}, code};
        lowIdx = c - 21'd101;
        rate   = 21'd0;
        if (code == 7'd0)
        begin
            case (speed)
                SPD_10:  rate = ppsMode ? 21'd19200  : 21'd10000;
                SPD_100: rate = ppsMode ? 21'd192000 : 21'd100000;
                default: rate = ppsMode ? 21'd1920000 : 21'd1000000;
            endcase
        end
        else if (code <= 7'd10)
        begin
            if (!ppsMode)
                rate = c * 21'd1000;
            else if (speed == SPD_10 || speed == SPD_100)
                rate = c * 21'd1920;
            else
                rate = c * 21'd19200;
        end
        else if (code <= 7'd100)
        begin
            case (speed)
                // codes 11 to 100 are undefined at 10 Mb/s; line rate is used in both modes
                SPD_10:  rate = ppsMode ? 21'd19200 : 21'd10000;
                SPD_100: rate = ppsMode ? c * 21'd1920 : c * 21'd1000;
                default: rate = ppsMode ? c * 21'd19200 : c * 21'd10000;
            endcase
        end
        else if (code <= 7'd115)
        begin
            if (ppsMode)
            begin
                rate = (lowIdx == 21'd0) ? 21'd64 : lowIdx * 21'd128;
                if (speed != SPD_10 && speed != SPD_100)
                    rate = rate * 21'd10;
            end
            else
            begin
                case (speed)
                    SPD_10:  rate = (lowIdx + 21'd1) * 21'd64;
                    SPD_100: rate = (lowIdx < 21'd3) ? (lowIdx + 21'd1) * 21'd640
                                                     : (lowIdx + 21'd1) * 21'd64;
                    default: rate = (lowIdx + 21'd1) * 21'd640;
                endcase
            end
        end
        else
        begin
            // codes above the table fall back to 64, the slowest 10 Mb/s entry, at every speed
            rate = ppsMode ? 21'd64 : 21'd64;
        end
    end

endmodule : ilr_rate_decode

//--- rtl/ilr_limiter.sv
// port ingress rate limiter: apb registers, per-priority token buckets
// assumes frame descriptors from the receive mac, one cycle per frame
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module ilr_limiter
    import ilr_pkg::*;
#(
    parameter int          REFILL_CYC   = REFILL_CYCLES,
    parameter logic [31:0] BURST_CREDIT = 32'h0003_0D40
)
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr,
    // port state
    input  wire logic [1:0]        linkSpeed,
    input  wire logic              portFcEnable,
    // frame descriptor from receive mac
    input  wire logic              frameValid,
    input  wire logic [13:0]       frameLen,
    input  wire logic [2:0]        framePrio,
    input  wire logic              frameBcast,
    input  wire logic              frameMcast,
    input  wire logic              frameFlood,
    // verdict
    output logic                   framePass,
    output logic                   frameDrop,
    output logic                   flowCtrl
);

    ////////////////////////////////////////////////////////////////////////
    // register decode

    // returns 0 cfg, 1..8 prio codes, 9 status, 15 unmapped
    function automatic logic [3:0] regSel(input logic [ADDR_W-1:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        if (a[1:0] != 2'b00 || a[ADDR_W-1:10] != '0)
            regSel = 4'hF;
        else if (idx == IDX_CFG)
            regSel = 4'h0;
        else if (idx >= IDX_PRIO0 && idx <= IDX_PRIO7)
            regSel = 4'(idx - IDX_PRIO0) + 4'h1;
        else if (idx == IDX_STATUS)
            regSel = 4'h9;
        else
            regSel = 4'hF;
    endfunction : regSel

    logic [7:0]        cfg_q;
    logic [6:0]        staged_q [NUM_PRIO];
    logic [6:0]        active_q [NUM_PRIO];
    logic [NUM_PRIO-1:0] exhausted;
    logic [3:0]        sel;
    logic              wrEn;

    assign sel  = regSel(paddr);
    // write lands at the completing access edge only
    assign wrEn = psel && penable && pready && pwrite;

    ////////////////////////////////////////////////////////////////////////
    // apb handshake: no wait states, pready in the first access cycle, keeps outputs registered

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (sel == 4'hF);
            if (psel && !penable)
            begin
                if (sel == 4'h0)
                    prdata <= {24'h00_0000, cfg_q & CFG_MASK};
                else if (sel >= 4'h1 && sel <= 4'h8)
                    prdata <= {25'h000_0000, staged_q[3'(sel - 4'h1)]};
                else if (sel == 4'h9)
                    prdata <= {16'h0000, exhausted, 7'h00, flowCtrl};
                else
                    prdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration and limit codes

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cfg_q <= CFG_RESET;
        else if (wrEn && sel == 4'h0)
            cfg_q <= pwdata[7:0] & CFG_MASK;
    end

    // codes are staged; a priority 7 write commits all eight at once
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < NUM_PRIO; i++)
            begin
                staged_q[i] <= CODE_RESET;
                active_q[i] <= CODE_RESET;
            end
        end
        else if (wrEn && sel >= 4'h1 && sel <= 4'h8)
        begin
            staged_q[3'(sel - 4'h1)] <= pwdata[6:0];
            if (sel == 4'h8)
            begin
                for (int i = 0; i < NUM_PRIO - 1; i++)
                    active_q[i] <= staged_q[i];
                active_q[NUM_PRIO-1] <= pwdata[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // config fields

    logic       portMode;
    logic       ppsMode;
    logic       rlFcEn;
    logic [1:0] limMode;
    logic       fcActive;

    assign portMode = cfg_q[CFG_PORT_BIT];
    assign ppsMode  = cfg_q[CFG_PPS_BIT];
    assign rlFcEn   = cfg_q[CFG_FC_BIT];
    assign limMode  = cfg_q[CFG_MODE_HI:CFG_MODE_LO];
    // needs port flow control as well
    assign fcActive = rlFcEn && portFcEnable;

    ////////////////////////////////////////////////////////////////////////
    // refill divider

    logic [31:0] refillCnt_q;
    logic        refill;

    assign refill = (refillCnt_q == 32'(REFILL_CYC - 1));

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            refillCnt_q <= 32'h0000_0000;
        else if (refill)
            refillCnt_q <= 32'h0000_0000;
        else
            refillCnt_q <= refillCnt_q + 32'h0000_0001;
    end

    ////////////////////////////////////////////////////////////////////////
    // rate decode, one per bucket

    logic [RATE_W-1:0] rate [NUM_PRIO];

    for (genvar g = 0; g < NUM_PRIO; g++)
    begin : g_dec
        ilr_rate_decode u_dec
        (
            .code    (active_q[g]),
            .speed   (linkSpeed),
            .ppsMode (ppsMode),
            .rate    (rate[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // frame classification and cost

    logic        counted;
    logic [2:0]  bucket;
    logic [15:0] bytes;
    logic [31:0] cost;

    always_comb
    begin
        case (limMode)
            LIM_ALL:   counted = 1'b1;
            LIM_BMF:   counted = frameBcast || frameMcast || frameFlood;
            LIM_BM:    counted = frameBcast || frameMcast;
            LIM_BCAST: counted = frameBcast;
            default:   counted = 1'b1;
        endcase
    end

    // port mode uses the priority 0 code for every frame
    assign bucket = portMode ? 3'd0 : framePrio;

    always_comb
    begin
        bytes = {2'b00, frameLen};
        if (cfg_q[CFG_IFG_BIT])
            bytes = bytes + IFG_BYTES;
        if (cfg_q[CFG_PRE_BIT] && !ppsMode)
            bytes = bytes + PRE_BYTES;
        cost = ppsMode ? PKT_COST : {13'h0000, bytes, 3'b000};
    end

    ////////////////////////////////////////////////////////////////////////
    // token buckets

    logic signed [CRED_W-1:0] credit_q [NUM_PRIO];
    logic                     exceed;
    logic                     charge;
    logic                     drop;

    assign exceed = credit_q[bucket] < $signed(cost);
    // over the limit: hold off the partner if allowed, else discard
    assign drop   = frameValid && counted && exceed && !fcActive;
    assign charge = frameValid && counted && !drop;

    for (genvar g = 0; g < NUM_PRIO; g++)
    begin : g_exh
        assign exhausted[g] = credit_q[g] < 32'sd0;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < NUM_PRIO; i++)
                credit_q[i] <= $signed(BURST_CREDIT);
        end
        else
        begin
            for (int i = 0; i < NUM_PRIO; i++)
            begin
                logic signed [CRED_W+1:0] nxt;
                nxt = {{2{credit_q[i][CRED_W-1]}}, credit_q[i]};
                if (refill)
                    nxt = nxt + $signed({13'h0000, rate[i]});
                if (charge && bucket == 3'(i))
                    nxt = nxt - $signed({2'b00, cost});
                // cap gives a bounded burst; floor stops runaway debt
                if (nxt > $signed({2'b00, BURST_CREDIT}))
                    nxt = $signed({2'b00, BURST_CREDIT});
                else if (nxt < -$signed({2'b00, BURST_CREDIT}))
                    nxt = -$signed({2'b00, BURST_CREDIT});
                credit_q[i] <= nxt[CRED_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // verdict and flow control

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            framePass <= 1'b0;
            frameDrop <= 1'b0;
        end
        else
        begin
            framePass <= frameValid && !drop;
            frameDrop <= drop;
        end
    end

    // held while any bucket is in debt; clears as refills repay it
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            flowCtrl <= 1'b0;
        else
            flowCtrl <= fcActive && (exhausted != '0);
    end

endmodule : ilr_limiter

//--- bench/ilr_limiter_assertions.sv
// port checker for the ingress rate limiter
// assumes one apb access cycle and one verdict per frame descriptor
`timescale 1ns/100ps
module ilr_limiter_chk
    import ilr_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // apb
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic              pready,
    input  wire logic [31:0]       prdata,
    input  wire logic              pslverr,
    // frames
    input  wire logic              portFcEnable,
    input  wire logic              frameValid,
    input  wire logic              framePass,
    input  wire logic              frameDrop,
    input  wire logic              flowCtrl
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic [6:0] code0_q;
    logic       mapped;
    assign mapped = paddr == 12'h00C || paddr == 12'h080
                    || (paddr[11:5] == 7'h02 && paddr[1:0] == 2'b00);
    // shadow of the staged priority 0 code
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            code0_q <= 7'h00;
        else if (psel && penable && pready && pwrite && paddr == 12'h040)
            code0_q <= pwdata[6:0];
    end
    ////////////////////////////////////////////////////////////////////////
    chk_verdict_once: assert property (frameValid |=> framePass ^ frameDrop)
        else $error("no single verdict after a frame");
    chk_verdict_idle: assert property (!frameValid |=> !framePass && !frameDrop)
        else $error("verdict without a frame");
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    chk_map_error: assert property (pready |-> pslverr == !mapped)
        else $error("error flag disagrees with map");
    chk_code_reserved: assert property (pready && !pwrite && paddr[11:5] == 7'h02
        |-> prdata[31:7] == 25'h0) else $error("code reserved bits set");
    chk_code_readback: assert property (pready && !pwrite && paddr == 12'h040
        |-> prdata[6:0] == code0_q) else $error("priority 0 code readback wrong");
    chk_flow_enable: assert property (flowCtrl |-> portFcEnable)
        else $error("flow control without port enable");
    chk_flow_cause: assert property ($rose(flowCtrl) |-> framePass || $past(framePass))
        else $error("flow control rose without a charged frame");
    chk_drop_no_flow: assert property (frameDrop |-> !flowCtrl)
        else $error("frame dropped while flow control held");
endmodule : ilr_limiter_chk

bind ilr_limiter ilr_limiter_chk u_chk (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .portFcEnable, .frameValid, .framePass,
    .frameDrop, .flowCtrl);

//--- bench/ilr_link_partner.sv
// link partner model: offers received frame descriptors to the limiter
// assumes the verdict pulse comes one cycle after each descriptor
`timescale 1ns/100ps
module ilr_link_partner
(
    // clock
    input  wire logic        clk,
    // descriptor
    output logic             frameValid,
    output logic [13:0]      frameLen,
    output logic [2:0]       framePrio,
    output logic             frameBcast,
    output logic             frameMcast,
    output logic             frameFlood,
    // verdict
    input  wire logic        framePass,
    input  wire logic        frameDrop
);
    initial
    begin
        frameValid = 1'b0;
        {frameLen, framePrio, frameBcast, frameMcast, frameFlood} = '0;
    end
    // called just after an edge; fields scrambled once released so a
    // stale descriptor is never mistaken for a live one
    task automatic send(input logic [13:0] len, input logic [2:0] cls,
                        input logic [2:0] prio, input int gap, output logic [1:0] vrd);
        begin
            frameValid <= 1'b1;
            frameLen   <= len;
            framePrio  <= prio;
            {frameBcast, frameMcast, frameFlood} <= cls;
            @(posedge clk);
            frameValid <= 1'b0;
            frameLen   <= ~len;
            framePrio  <= ~prio;
            {frameBcast, frameMcast, frameFlood} <= ~cls;
            @(posedge clk);
            // both verdict pulses, so a missing or double answer shows up
            vrd = {framePass, frameDrop};
            repeat (gap) @(posedge clk);
        end
    endtask : send
endmodule : ilr_link_partner

//--- bench/ilr_limiter_test.sv
// self-checking bench for the ingress rate limiter
// assumes apb registers at index*4 and the link partner model for frames
`timescale 1ns/100ps
module ilr_limiter_test
    import ilr_pkg::*;
;
    // short refill period and burst keep the run small
    localparam int          RCYC  = 4000;
    localparam logic [31:0] BURST = 32'h0001_86A0;
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0;
    logic              pready, pslverr, flowCtrl, framePass, frameDrop;
    logic [31:0]       prdata;
    logic [1:0]        linkSpeed = 2'b00;
    logic              portFcEnable = 1'b0;
    logic              frameValid, frameBcast, frameMcast, frameFlood;
    logic [13:0]       frameLen;
    logic [2:0]        framePrio;
    logic [31:0]       rd;
    logic              er;
    int                p, q, num_errors = 0, n_tests = 0;
    logic [7:0]        costCfg [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h20, 8'h21};
    int                costExp [6] = '{125, 115, 111, 104, 100, 100};
    logic [7:0]        rCfg [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                     8'h00, 8'h20, 8'h20};
    logic [1:0]        rSpd [10] = '{2'b00, 2'b00, 2'b00, 2'b01, 2'b00, 2'b01, 2'b00,
                                     2'b01, 2'b00, 2'b10};
    logic [6:0]        rCode [10] = '{7'h00, 7'h01, 7'h01, 7'h07, 7'h0B, 7'h0B, 7'h65,
                                      7'h66, 7'h05, 7'h01};
    logic              rCommit [10] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
                                        1'b1, 1'b1};
    int                rExp [10] = '{10, 10, 1, 7, 10, 11, 0, 1, 9, 19};

    ilr_limiter #(.REFILL_CYC(RCYC), .BURST_CREDIT(BURST)) dut (.clk, .rstn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .linkSpeed,
        .portFcEnable, .frameValid, .frameLen, .framePrio, .frameBcast, .frameMcast,
        .frameFlood, .framePass, .frameDrop, .flowCtrl);
    ilr_link_partner lp (.clk, .frameValid, .frameLen, .framePrio, .frameBcast,
        .frameMcast, .frameFlood, .framePass, .frameDrop);

    initial
    begin
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, num_errors);
            if (num_errors == 0 && n_tests > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask : wrap_up
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_tests++;
            if (got !== exp)
            begin
                num_errors++;
                $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask : check
    // setup, then access held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        begin
            @(posedge clk);
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= wr;
            paddr   <= a;
            pwdata  <= wd;
            @(posedge clk);
            penable <= 1'b1;
            n = 0;
            @(posedge clk);
            while (pready !== 1'b1)
            begin
                n++;
                if (n > 16)
                begin
                    num_errors++;
                    wrap_up();
                end
                @(posedge clk);
            end
            rd = prdata;
            er = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb
    task automatic restart(input logic [7:0] cfg, input logic [1:0] spd, input logic fc);
        begin
            rstn         <= 1'b0;
            linkSpeed    <= spd;
            portFcEnable <= fc;
            repeat (20) @(posedge clk);
            rstn <= 1'b1;
            apb(1'b1, 12'h00C, {24'h0, cfg});
        end
    endtask : restart
    // counts frames forwarded (p) and discarded (q) out of n
    task automatic burst(input int n, input logic [13:0] len, input logic [2:0] cls,
                         input logic [2:0] prio);
        logic [1:0] v;
        begin
            p = 0;
            q = 0;
            repeat (n)
            begin
                lp.send(len, cls, prio, 0, v);
                p += int'(v === 2'b10);
                q += int'(v === 2'b01);
            end
        end
    endtask : burst
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        restart(8'h00, 2'b00, 1'b0);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b0, 12'h040, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b1, 12'h040, 32'h0000_00FF);
        apb(1'b0, 12'h040, 32'h0000_0000);
        check(rd, 32'h0000_007F);
        apb(1'b1, 12'h050, 32'h0000_002A);
        apb(1'b0, 12'h050, 32'h0000_0000);
        check(rd, 32'h0000_002A);
        apb(1'b0, 12'h100, 32'h0000_0000);
        check(er, 1'b1);
        for (int i = 0; i < 6; i++)
        begin
            restart(costCfg[i], 2'b00, 1'b0);
            burst(130, 14'h0064, 3'b100, 3'h0);
            check(p, costExp[i]);
            check(q, 130 - costExp[i]);
        end
        // counted classes drop once the bucket is empty, others pass
        for (int m = 0; m < 4; m++)
            for (int c = 0; c < 4; c++)
            begin
                restart({4'h0, m[1:0], 2'b00}, 2'b00, 1'b0);
                burst(130, 14'h0064, 3'b100, 3'h0);
                burst(1, 14'h0064, 3'((4'h1 << c) >> 1), 3'h0);
                check(p, (c >= m) ? 0 : 1);
            end
        for (int b = 0; b < 2; b++)
        begin
            restart(b ? 8'h40 : 8'h00, 2'b00, 1'b0);
            burst(130, 14'h0064, 3'b100, 3'h0);
            burst(1, 14'h0064, 3'b100, 3'h5);
            check(p, 1 - b);
        end
        for (int f = 0; f < 2; f++)
        begin
            restart(8'h10, 2'b00, f[0]);
            burst(130, 14'h0064, 3'b100, 3'h0);
            check(p, f ? 130 : 125);
            check(q, f ? 0 : 5);
            check(flowCtrl, f[0]);
            // status: bucket 0 in debt and flow control only when charged past empty
            apb(1'b0, 12'h080, 32'h0000_0000);
            check(rd, f ? 32'h0000_0101 : 32'h0000_0000);
        end
        // empty the bucket, let exactly one refill land, then measure it
        for (int i = 0; i < 10; i++)
        begin
            restart(rCfg[i], rSpd[i], 1'b0);
            apb(1'b1, 12'h040, {25'h000_0000, rCode[i]});
            if (rCommit[i])
                apb(1'b1, 12'h05C, {25'h000_0000, rCode[i]});
            burst(130, 14'h04E2, 3'b100, 3'h0);
            repeat (RCYC) @(posedge clk);
            burst(20, 14'h007D, 3'b100, 3'h0);
            check(p, rExp[i]);
        end
        wrap_up();
    end
endmodule : ilr_limiter_test
